/* File: hw/scrx_pkg.sv */
package scrx_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL  = 5'h00;
  localparam logic [4:0] OFS_MODE  = 5'h04;
  localparam logic [4:0] OFS_STAT  = 5'h08;
  localparam logic [4:0] OFS_RDATA = 5'h0c;
  localparam logic [4:0] OFS_TDATA = 5'h10;

  // serial_control_reg fields
  localparam int CTL_RIE  = 0;  // receive_irq_enable
  localparam int CTL_TIE  = 1;  // transmit irq enable
  localparam int CTL_TRANSMIT_END_IRQ_ENABLE = 2;  // transmit_end_irq_enable
  localparam int CTL_TE   = 3;  // transmit_enable
  localparam int CTL_RE   = 4;  // receive_enable
  localparam int CTL_CLOCK_OUTPUT_ENABLE = 5;  // clock_output_enable
  localparam int CTL_CLOCK_LEVEL_SELECT = 6;  // clock_level_select

  // serial_mode_reg fields
  localparam int MOD_GM   = 0;  // gsm_timing_select
  localparam int MOD_SMIF = 1;  // smart-card mode
  localparam int MOD_SEL  = 2;  // channel 0 clocked synchronous select mode

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS       = 10;
  localparam int SCK_HALF_NS  = 40;  // half period of the smart-card clock
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int SC_BIT_CLKS  = 32;  // card clocks per bit
  localparam int BIT_CYC      = 2 * SCK_HALF_CYC * SC_BIT_CLKS;
  localparam int FRAME_BITS   = 9;   // data bits plus parity/stop after start
  localparam int SYNC_BITS    = 8;

  localparam logic [15:0] BIT_LAST  = 16'(BIT_CYC - 1);
  localparam logic [15:0] HALF_LAST = 16'(BIT_CYC / 2 - 1);
  localparam logic [15:0] SCK_LAST  = 16'(SCK_HALF_CYC - 1);
  localparam logic [3:0]  RX_LAST   = 4'(FRAME_BITS - 1);
  localparam logic [3:0]  SY_LAST   = 4'(SYNC_BITS - 1);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10
  } scrx_rx_state_type;

  // serial_status_reg layout, msb first
  typedef struct packed {
    logic transmit_end_flag;  // transmit_end_flag
    logic transmit_empty_flag;  // transmit_empty_flag
    logic error_signal_flag;   // error_signal_flag
    logic parity_error_flag;   // parity_error_flag
    logic framing_error_flag;   // framing_error_flag
    logic overrun_flag;  // overrun_flag
    logic receive_full_flag;  // receive_full_flag
  } scrx_flags_type;

  localparam scrx_flags_type STAT_RST = 7'h60;

endpackage

/* File: hw/scrx_sci.sv */
// Operation
// - bad parity on a smart-card frame sets the parity error flag
// - parity error with receive irq enable raises receive-error irq
// - no receive-full flag for a frame with a receive error
// - good parity sets receive-full, leaves parity error clear, may irq
// - dma read of received byte clears receive-full automatically
// - overrun or parity error gives error irq, no dma request
// - byte with parity error still lands in receive data register
// - gsm timing lets enable bits fix clock level, pulses full width
// - gsm timing: clock stop waits for current pulse end, then holds fixed level; otherwise it stops at once
// - clock restart begins with a full normal-duty pulse
// - deselected slave floats transmit pin, holds internal clock high
// - low select input means selected; processing starts at once
// - normal mode: transmit-end flag and enable request transmit-end irq
// - normal mode: transmit-empty requests transmit irq; dma transfer clears flag
// - normal mode: overrun, parity or framing error gives error irq
// - simultaneous transmit and transmit-end: transmit irq first
// - smart card: no transmit-end irq, errors include error-signal
// - smart-card transmit sets transmit-empty together with transmit-end
module scrx_sci
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // serial pins
  input  wire logic        rxd_in,
  output logic             txd_out,
  output logic             txd_oe_out,
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe_out,
  input  wire logic        external_irq_seven_n_in,
  // transmitter events, same clock
  input  wire logic        tx_empty_evt_in,
  input  wire logic        tx_end_evt_in,
  input  wire logic        err_sig_evt_in,
  // dma controller acknowledges
  input  wire logic        dma_rx_ack_in,
  input  wire logic        dma_tx_ack_in,
  // interrupt and dma requests
  output logic             receive_error_irq_out,
  output logic             receive_full_irq_out,
  output logic             transmit_empty_irq_out,
  output logic             transmit_end_irq_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]                 ctrl;
    logic [7:0]                 mode;
    scrx_pkg::scrx_flags_type   stat;
    logic [7:0]                 rdata;
    logic [7:0]                 tdata;
    logic                       ack;
    logic [7:0]                 rd_data;
    logic                       rx_s1;
    logic                       rx_s2;
    logic                       sck_s1;
    logic                       sck_s2;
    logic                       sel_s1;
    logic                       sel_s2;
    logic                       sck_int_d;
    scrx_pkg::scrx_rx_state_type rx_st;
    logic [15:0]                rx_cnt;
    logic [3:0]                 rx_bit;
    logic [8:0]                 rx_shift;
    logic [15:0]                ck_cnt;
    logic                       ck_lvl;
    logic                       ck_run;
    logic [3:0]                 sy_cnt;
    logic [7:0]                 sy_rx;
    logic [7:0]                 sy_tx;
    logic                       txd;
  } scrx_state_type;

  scrx_state_type state_reg;
  scrx_state_type state_next;

  // end of a received byte: overrun wins, errored bytes never set full
  function automatic scrx_pkg::scrx_flags_type rx_end(scrx_pkg::scrx_flags_type f,
                                                      logic perr, logic ferr);
    scrx_pkg::scrx_flags_type r;
    r = f;
    if (f.receive_full_flag)
      r.overrun_flag = 1'b1;
    else if (perr || ferr)
    begin
      r.parity_error_flag = r.parity_error_flag | perr;
      r.framing_error_flag = r.framing_error_flag | ferr;
    end
    else
      r.receive_full_flag = 1'b1;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // decoded controls
  // ----------------------------------------------------------------
  logic bus_req;
  logic smart;
  logic sync_sel;
  logic selected;
  logic sck_int;

  assign bus_req  = avs_read_in | avs_write_in;
  assign smart    = state_reg.mode[scrx_pkg::MOD_SMIF];
  assign sync_sel = state_reg.mode[scrx_pkg::MOD_SEL];
  assign selected = ~state_reg.sel_s2;
  // deselected slave sees a clock stuck high, so nothing shifts
  assign sck_int  = selected ? state_reg.sck_s2 : 1'b1;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic rx_en;
    logic sy_en;
    logic ck_end;
    logic [7:0] wd;
    rx_en = 1'b0;
    sy_en = 1'b0;
    ck_end = 1'b0;
    wd = avs_writedata_in[7:0];
    state_next = state_reg;
    rx_en = state_reg.ctrl[scrx_pkg::CTL_RE] & ~sync_sel;
    sy_en = sync_sel & (state_reg.ctrl[scrx_pkg::CTL_RE] | state_reg.ctrl[scrx_pkg::CTL_TE]);

    // pin synchronisers
    state_next.rx_s1     = rxd_in;
    state_next.rx_s2     = state_reg.rx_s1;
    state_next.sck_s1    = sck_in;
    state_next.sck_s2    = state_reg.sck_s1;
    state_next.sel_s1    = external_irq_seven_n_in;
    state_next.sel_s2    = state_reg.sel_s1;
    state_next.sck_int_d = sck_int;

    // bus: one wait cycle, read data latched while waiting
    state_next.ack = bus_req & ~state_reg.ack;
    if (bus_req && !state_reg.ack)
    begin
      case (avs_address_in)
        scrx_pkg::OFS_CTRL:  state_next.rd_data = state_reg.ctrl;
        scrx_pkg::OFS_MODE:  state_next.rd_data = state_reg.mode;
        scrx_pkg::OFS_STAT:  state_next.rd_data = {1'b0, state_reg.stat};
        scrx_pkg::OFS_RDATA: state_next.rd_data = state_reg.rdata;
        scrx_pkg::OFS_TDATA: state_next.rd_data = state_reg.tdata;
        default:             state_next.rd_data = scrx_pkg::DATA_RST;
      endcase
    end

    // register writes take effect on the edge that completes the request;
    // status bits clear by writing 0, sets below still win
    if (avs_write_in && state_reg.ack && avs_byteenable_in[0])
    begin
      case (avs_address_in)
        scrx_pkg::OFS_CTRL:  state_next.ctrl  = wd;
        scrx_pkg::OFS_MODE:  state_next.mode  = wd;
        scrx_pkg::OFS_STAT:  state_next.stat  = state_reg.stat & wd[6:0];
        scrx_pkg::OFS_TDATA: state_next.tdata = wd;
        default:             state_next.mode  = state_reg.mode;
      endcase
    end

    // dma transfers clear their request flags
    if (dma_rx_ack_in)
      state_next.stat.receive_full_flag = 1'b0;
    if (dma_tx_ack_in)
    begin
      state_next.stat.transmit_empty_flag = 1'b0;
      if (smart)
        state_next.stat.transmit_end_flag = 1'b0;
    end

    // transmitter events
    if (tx_empty_evt_in)
      state_next.stat.transmit_empty_flag = 1'b1;
    if (tx_end_evt_in)
    begin
      state_next.stat.transmit_end_flag = 1'b1;
      if (smart)
        state_next.stat.transmit_empty_flag = 1'b1;
    end
    if (err_sig_evt_in && smart)
      state_next.stat.error_signal_flag = 1'b1;

    // smart-card / asynchronous receiver, lsb first
    case (state_reg.rx_st)
      scrx_pkg::RX_IDLE:
      begin
        state_next.rx_cnt = '0;
        if (rx_en && !state_reg.rx_s2)
          state_next.rx_st = scrx_pkg::RX_START;
      end
      scrx_pkg::RX_START:
      begin
        state_next.rx_cnt = state_reg.rx_cnt + 16'h0001;
        if (state_reg.rx_cnt == scrx_pkg::HALF_LAST)
        begin
          state_next.rx_cnt = '0;
          state_next.rx_bit = '0;
          // a glitch shorter than half a bit is not a start
          state_next.rx_st  = state_reg.rx_s2 ? scrx_pkg::RX_IDLE : scrx_pkg::RX_DATA;
        end
      end
      scrx_pkg::RX_DATA:
      begin
        state_next.rx_cnt = state_reg.rx_cnt + 16'h0001;
        if (state_reg.rx_cnt == scrx_pkg::BIT_LAST)
        begin
          state_next.rx_cnt   = '0;
          state_next.rx_bit   = state_reg.rx_bit + 4'h1;
          state_next.rx_shift = {state_reg.rx_s2, state_reg.rx_shift[8:1]};
          if (state_reg.rx_bit == scrx_pkg::RX_LAST)
          begin
            state_next.rx_st = scrx_pkg::RX_IDLE;
            // the byte is kept even when its parity is bad
            if (!state_reg.stat.receive_full_flag)
              state_next.rdata = state_next.rx_shift[7:0];
            state_next.stat = rx_end(state_next.stat,
                                     smart & (^state_next.rx_shift),
                                     ~smart & ~state_reg.rx_s2);
          end
        end
        if (!rx_en)
          state_next.rx_st = scrx_pkg::RX_IDLE;
      end
      default: state_next.rx_st = scrx_pkg::RX_IDLE;
    endcase

    // clocked synchronous slave with select input
    if (!sy_en || !selected)
    begin
      state_next.sy_cnt = '0;
      state_next.sy_tx  = state_reg.tdata;
      state_next.txd    = state_reg.tdata[0];
    end
    else if (sck_int && !state_reg.sck_int_d)
    begin
      state_next.sy_rx  = {state_reg.rx_s2, state_reg.sy_rx[7:1]};
      state_next.sy_cnt = state_reg.sy_cnt + 4'h1;
      if (state_reg.sy_cnt == scrx_pkg::SY_LAST)
      begin
        state_next.sy_cnt = '0;
        if (state_reg.ctrl[scrx_pkg::CTL_RE])
        begin
          if (!state_reg.stat.receive_full_flag)
            state_next.rdata = state_next.sy_rx;
          state_next.stat = rx_end(state_next.stat, 1'b0, 1'b0);
        end
        state_next.sy_tx = state_reg.tdata;
        if (state_reg.ctrl[scrx_pkg::CTL_TE])
          state_next.stat.transmit_empty_flag = 1'b1;
      end
    end
    else if (!sck_int && state_reg.sck_int_d)
    begin
      state_next.txd   = state_reg.sy_tx[0];
      state_next.sy_tx = {1'b0, state_reg.sy_tx[7:1]};
    end

    // smart-card clock output; with gsm timing a half period is never cut short
    ck_end = state_reg.ck_cnt == scrx_pkg::SCK_LAST;
    if (state_reg.ck_run)
    begin
      state_next.ck_cnt = ck_end ? 16'h0000 : state_reg.ck_cnt + 16'h0001;
      if (!state_reg.mode[scrx_pkg::MOD_GM] && !state_reg.ctrl[scrx_pkg::CTL_CLOCK_OUTPUT_ENABLE])
      begin
        state_next.ck_run = 1'b0;
        state_next.ck_lvl = state_reg.ctrl[scrx_pkg::CTL_CLOCK_LEVEL_SELECT];
      end
      else if (ck_end)
      begin
        // stop only once the level already equals the fixed one
        if (!state_reg.ctrl[scrx_pkg::CTL_CLOCK_OUTPUT_ENABLE]
            && state_reg.ck_lvl == state_reg.ctrl[scrx_pkg::CTL_CLOCK_LEVEL_SELECT])
          state_next.ck_run = 1'b0;
        else
          state_next.ck_lvl = ~state_reg.ck_lvl;
      end
    end
    else
    begin
      state_next.ck_lvl = state_reg.ctrl[scrx_pkg::CTL_CLOCK_LEVEL_SELECT];
      state_next.ck_cnt = '0;
      if (state_reg.ctrl[scrx_pkg::CTL_CLOCK_OUTPUT_ENABLE])
      begin
        state_next.ck_run = 1'b1;
        state_next.ck_lvl = ~state_reg.ctrl[scrx_pkg::CTL_CLOCK_LEVEL_SELECT];
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      state_reg       <= '0;
      state_reg.ctrl  <= scrx_pkg::CTRL_RST;
      state_reg.mode  <= scrx_pkg::MODE_RST;
      state_reg.stat  <= scrx_pkg::STAT_RST;
      state_reg.rx_s1 <= 1'b1;
      state_reg.rx_s2 <= 1'b1;
      state_reg.sel_s1 <= 1'b1;
      state_reg.sel_s2 <= 1'b1;
      state_reg.sck_int_d <= 1'b1;
      state_reg.txd   <= 1'b1;
      state_reg.rx_st <= scrx_pkg::RX_IDLE;
    end
    else
      state_reg <= state_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign avs_waitrequest_out = bus_req & ~state_reg.ack;
  assign avs_readdata_out    = {24'h000000, state_reg.rd_data};
  assign txd_out             = state_reg.txd;
  assign txd_oe_out          = sync_sel & selected & state_reg.ctrl[scrx_pkg::CTL_TE];
  assign sck_out             = state_reg.ck_lvl;
  assign sck_oe_out          = smart;

  // requests are plain levels of flag and enable
  assign receive_error_irq_out  = state_reg.ctrl[scrx_pkg::CTL_RIE]
                                  & (state_reg.stat.overrun_flag | state_reg.stat.parity_error_flag
                                     | (state_reg.stat.framing_error_flag & ~smart)
                                     | (state_reg.stat.error_signal_flag & smart));
  assign receive_full_irq_out   = state_reg.ctrl[scrx_pkg::CTL_RIE]
                                  & state_reg.stat.receive_full_flag;
  assign transmit_empty_irq_out = state_reg.ctrl[scrx_pkg::CTL_TIE]
                                  & (smart ? state_reg.stat.transmit_end_flag
                                           : state_reg.stat.transmit_empty_flag);
  // transmit-end yields while a transmit request stands
  assign transmit_end_irq_out   = state_reg.ctrl[scrx_pkg::CTL_TRANSMIT_END_IRQ_ENABLE] & ~smart
                                  & state_reg.stat.transmit_end_flag
                                  & ~transmit_empty_irq_out;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_frame_end;
    state_reg.rx_st == scrx_pkg::RX_DATA && state_reg.rx_cnt == scrx_pkg::BIT_LAST
      && state_reg.rx_bit == scrx_pkg::RX_LAST && smart && !state_reg.stat.receive_full_flag;
  endsequence

  chk_parity_sets_per: assert property (s_frame_end ##0 (^state_next.rx_shift)
    |=> state_reg.stat.parity_error_flag && $stable(state_reg.stat.receive_full_flag))
    else $error("bad parity did not set parity error only");
  chk_good_sets_full: assert property (s_frame_end ##0 !(^state_next.rx_shift)
    |=> state_reg.stat.receive_full_flag && state_reg.stat.parity_error_flag == $past(state_reg.stat.parity_error_flag))
    else $error("good frame did not set receive full");
  chk_error_keeps_data: assert property (s_frame_end ##0 (^state_next.rx_shift)
    |=> state_reg.rdata == $past(state_next.rx_shift[7:0]))
    else $error("errored byte not stored");
  chk_dma_clears_full: assert property (dma_rx_ack_in && !(state_reg.rx_st == scrx_pkg::RX_DATA)
    && !(sync_sel && selected) |=> !state_reg.stat.receive_full_flag)
    else $error("dma read did not clear receive full");
  chk_eri_follows: assert property (state_reg.ctrl[scrx_pkg::CTL_RIE] && state_reg.stat.parity_error_flag
    |-> receive_error_irq_out && !(state_reg.stat.receive_full_flag == 1'b0 && receive_full_irq_out))
    else $error("parity error without error request");
  chk_tei_priority: assert property (transmit_empty_irq_out |-> !transmit_end_irq_out)
    else $error("transmit-end request beside transmit request");
  chk_no_tei_smart: assert property (smart |-> !transmit_end_irq_out)
    else $error("transmit-end request in smart-card mode");
  chk_sc_transmit_end_flag_transmit_empty_flag: assert property (smart && tx_end_evt_in |=> state_reg.stat.transmit_empty_flag
    && state_reg.stat.transmit_end_flag)
    else $error("transmit-empty not set with transmit-end");
  chk_desel_float: assert property (!selected |-> !txd_oe_out && sck_int)
    else $error("deselected slave drives or clocks");
  chk_clock_stop_level: assert property (!state_reg.ck_run && !$past(state_reg.ck_run)
    |-> sck_out == $past(state_reg.ctrl[scrx_pkg::CTL_CLOCK_LEVEL_SELECT]))
    else $error("stopped clock not at the chosen level");
  chk_halt_full_pulse: assert property ($fell(state_reg.ck_run) && state_reg.mode[scrx_pkg::MOD_GM]
    |-> $past(state_reg.ck_cnt) == scrx_pkg::SCK_LAST && sck_out == state_reg.ctrl[scrx_pkg::CTL_CLOCK_LEVEL_SELECT])
    else $error("clock halted mid pulse or at wrong level");
  chk_restart_pulse: assert property ($rose(state_reg.ck_run) |-> state_reg.ck_cnt == 16'h0000
    ##1 $stable(sck_out)[*3])
    else $error("restart pulse shorter than normal");

endmodule // scrx_sci

/* File: testbench/scrx_card_model.sv */
// --------------------------------------------------------------
// smart card model: sends receive frames towards the block
// --------------------------------------------------------------
module scrx_card_model
(
  // clock
  input  wire logic clk_in,
  // card data line and clocked synchronous master lines
  input  wire logic txd_in,
  output logic      rxd_out,
  output logic      sck_out,
  output logic      sel_n_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // the lines have pull-ups, so they idle high between frames
  initial
  begin
    rxd_out   = 1'b1;
    sck_out   = 1'b1;
    sel_n_out = 1'b1;
  end

  // select the block as a clocked synchronous slave, or release it; the
  // select only moves while the clock idles high after the last bit
  task automatic select(input logic on);
    @(posedge clk_in);
    sel_n_out <= ~on;
    repeat (4) @(posedge clk_in);
  endtask

  // master byte exchange, lsb first: data set with the falling clock, the
  // reply taken late in the high phase for margin; 8 cycles per bit
  task automatic xfer(input logic [7:0] d, output logic [7:0] r);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_in);
      sck_out <= 1'b0;
      rxd_out <= d[i];
      repeat (4) @(posedge clk_in);
      sck_out <= 1'b1;
      repeat (3) @(posedge clk_in);
      r[i] = txd_in;
    end
    repeat (4) @(posedge clk_in);
  endtask

  // start, 8 bits lsb first, even parity (inverted when bad), guard
  task automatic send(input logic [7:0] d, input logic bad);
    logic [10:0] f;
    f = {1'b1, (^d) ^ bad, d, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      @(posedge clk_in);
      rxd_out <= f[i];
      repeat (scrx_pkg::BIT_CYC - 1) @(posedge clk_in);
    end
    repeat (scrx_pkg::BIT_CYC) @(posedge clk_in);
  endtask
endmodule // scrx_card_model

/* File: testbench/scrx_sci_test.sv */
module scrx_sci_test;
  timeunit 1ns;
  timeprecision 1ps;

  // --------------------------------------------------------------
  // signals
  // --------------------------------------------------------------
  logic        clk_in = 1'b0, nrst_in = 1'b0, rd = 1'b0, wr = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic        wreq, rxd, sck, txd, sck_m, sel_n;
  // event lines: 0 dma rx ack, 1 dma tx ack, 2 tx empty, 3 tx end, 4 error signal
  logic [4:0]  ev = 5'h00;
  logic [1:0]  oe;
  logic [3:0]  irq;
  logic [7:0]  q, got;
  int          mismatches = 0, checks_done = 0, n;

  // clock runs at 100 mhz
  initial
  begin
    forever #5 clk_in = ~clk_in;
  end

  scrx_card_model scrx_card_model_i (.clk_in(clk_in), .txd_in(txd), .rxd_out(rxd),
    .sck_out(sck_m), .sel_n_out(sel_n));

  scrx_sci scrx_sci_i (
    .clk_in(clk_in), .nrst_in(nrst_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(4'h1),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .rxd_in(rxd), .txd_out(txd),
    .txd_oe_out(oe[1]), .sck_in(sck_m), .sck_out(sck), .sck_oe_out(oe[0]),
    .external_irq_seven_n_in(sel_n), .tx_empty_evt_in(ev[2]), .tx_end_evt_in(ev[3]),
    .err_sig_evt_in(ev[4]), .dma_rx_ack_in(ev[0]), .dma_tx_ack_in(ev[1]),
    .receive_error_irq_out(irq[3]), .receive_full_irq_out(irq[2]),
    .transmit_empty_irq_out(irq[1]), .transmit_end_irq_out(irq[0]));

  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one avalon cycle; request holds until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_in);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do @(posedge clk_in); while (wreq !== 1'b0);
    q = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // one-cycle pulse on the chosen dma acknowledge or event lines, then settle
  task automatic pulse(input logic [4:0] m);
    @(posedge clk_in);
    ev <= m;
    @(posedge clk_in);
    ev <= 5'h00;
    repeat (2) @(negedge clk_in);
  endtask

  task automatic wait_irq(input int b);
    for (n = 0; n < 4000 && irq[b] !== 1'b1; n++) @(posedge clk_in);
    @(negedge clk_in);
  endtask

  // hang guard: longest sequence is well under 20000 cycles
  initial
  begin
    #200us;
    mismatches++;
    finish_test();
  end

  // --------------------------------------------------------------
  // tests
  // --------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    bus(0, scrx_pkg::OFS_STAT, 8'h0); chk("status reset", 8'h60, q);
    bus(0, 5'h1c, 8'h0); chk("unmapped", 8'h00, q);
    bus(1, scrx_pkg::OFS_MODE, 8'h03);
    bus(1, scrx_pkg::OFS_CTRL, 8'h11);
    // good frame
    scrx_card_model_i.send(8'ha5, 1'b0);
    wait_irq(2); chk("full irq", 8'h01, {7'h0, irq[2]});
    bus(0, scrx_pkg::OFS_STAT, 8'h0); chk("status good", 8'h61, q);
    bus(0, scrx_pkg::OFS_RDATA, 8'h0); chk("rdata good", 8'ha5, q);
    // a second byte before the first is taken overruns and is dropped
    scrx_card_model_i.send(8'h5a, 1'b0);
    wait_irq(3); chk("ovr irq", 8'h01, {7'h0, irq[3]});
    bus(0, scrx_pkg::OFS_STAT, 8'h0); chk("status ovr", 8'h63, q);
    bus(0, scrx_pkg::OFS_RDATA, 8'h0); chk("rdata kept", 8'ha5, q);
    bus(1, scrx_pkg::OFS_STAT, 8'h61);
    pulse(5'h01); chk("full after dma", 8'h00, {7'h0, irq[2]});
    bus(0, scrx_pkg::OFS_STAT, 8'h0); chk("status dma", 8'h60, q);
    // bad parity frame
    scrx_card_model_i.send(8'h3c, 1'b1);
    wait_irq(3); chk("err irq", 8'h01, {7'h0, irq[3]});
    chk("no full irq", 8'h00, {7'h0, irq[2]});
    bus(0, scrx_pkg::OFS_STAT, 8'h0); chk("status bad", 8'h68, q);
    bus(0, scrx_pkg::OFS_RDATA, 8'h0); chk("rdata bad", 8'h3c, q);
    bus(1, scrx_pkg::OFS_STAT, 8'h60);
    @(negedge clk_in); chk("err cleared", 8'h00, {7'h0, irq[3]});
    // clock enable starts the card clock toggling; smart-card mode drives the clock pin
    bus(1, scrx_pkg::OFS_CTRL, 8'h31);
    n = 0;
    repeat (20) @(negedge clk_in) n += int'(sck === 1'b1);
    chk("clock runs", 8'h01, 8'(n >= 8 && n <= 12));
    chk("clock pin", 8'h01, {6'h0, oe});
    // receiver off, level high, clock off, then at least one clock period
    bus(1, scrx_pkg::OFS_CTRL, 8'h41);
    repeat (12) @(posedge clk_in);
    n = 0;
    repeat (16) @(negedge clk_in) n += int'(sck === 1'b1);
    chk("clock held", 8'd16, 8'(n));
    // transmit requests
    bus(1, scrx_pkg::OFS_CTRL, 8'h17);
    @(negedge clk_in); chk("sc irqs", 8'h02, {6'h0, irq[1:0]});
    pulse(5'h02); chk("sc tx dma", 8'h00, {6'h0, irq[1:0]});
    pulse(5'h08); bus(0, scrx_pkg::OFS_STAT, 8'h0); chk("sc transmit_end_flag", 8'h60, q);
    pulse(5'h10); chk("ers irq", 8'h01, {7'h0, irq[3]});
    bus(1, scrx_pkg::OFS_MODE, 8'h00);
    @(negedge clk_in); chk("priority", 8'h02, {6'h0, irq[1:0]});
    pulse(5'h02); chk("tx dma", 8'h01, {6'h0, irq[1:0]});
    bus(1, scrx_pkg::OFS_STAT, 8'h00);
    @(negedge clk_in); chk("transmit_end_flag cleared", 8'h00, {6'h0, irq[1:0]});
    pulse(5'h04); chk("tx empty", 8'h02, {6'h0, irq[1:0]});
    // clocked synchronous slave behind the select input
    bus(1, scrx_pkg::OFS_MODE, 8'h04);
    bus(1, scrx_pkg::OFS_CTRL, 8'h18);
    bus(1, scrx_pkg::OFS_TDATA, 8'h5a);
    chk("desel pins", 8'h00, {6'h0, oe});
    scrx_card_model_i.select(1'b1);
    chk("sel pins", 8'h02, {6'h0, oe});
    scrx_card_model_i.xfer(8'hc3, got);
    chk("sync tx", 8'h5a, got);
    scrx_card_model_i.select(1'b0);
    chk("released pins", 8'h00, {6'h0, oe});
    bus(0, scrx_pkg::OFS_RDATA, 8'h0); chk("sync rx", 8'hc3, q);
    finish_test();
  end
endmodule // scrx_sci_test
